// ---- verilog/pms_pkg.sv ----
// pms_pkg: constants, register map and state codes of the power-mode supervisor
`default_nettype none
package pms_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_NS      = 50;
  localparam int STARTUP_NS  = 1000;
  localparam int STARTUP_CYC = (STARTUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 5;
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_WMASK  = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_IMASK  = 12'h00C;
  localparam logic [11:0] OFF_MODE   = 12'h010;
  // ------------------------------------------------------------
  // control fields and reset values
  // ------------------------------------------------------------
  localparam int CT_MON_EN   = 0;
  localparam int CT_MON_FALL = 1;
  localparam int CT_MON_RISE = 2;
  localparam int CT_STOP_LP  = 3;
  localparam int CT_DEEP     = 4;
  localparam int CT_STANDBY  = 5;
  localparam int CT_LVL_LO   = 6;
  localparam int CTRL_W      = 9;
  localparam int WMASK_W     = 21;
  localparam logic [CTRL_W-1:0]  CTRL_RST  = 9'h000;
  localparam logic [WMASK_W-1:0] WMASK_RST = 21'h000000;
  // ------------------------------------------------------------
  // status / interrupt bits
  // ------------------------------------------------------------
  localparam int SB_MON_FALL  = 0;
  localparam int SB_MON_RISE  = 1;
  localparam int SB_STBY_EXIT = 2;
  localparam int SB_STOP_WAKE = 3;
  localparam int STAT_W       = 4;
  localparam logic [STAT_W-1:0] STAT_RST = 4'h0;
  // ------------------------------------------------------------
  // synchroniser lanes
  // ------------------------------------------------------------
  localparam int IX_MAIN_OK  = 0;
  localparam int IX_ANA_OK   = 1;
  localparam int IX_MON_LOW  = 2;
  localparam int IX_RSTPIN_N = 3;
  localparam int IX_WDG      = 4;
  localparam int IX_WAKE     = 5;
  localparam int IX_RTC      = 6;
  localparam int IX_ANA_OFF  = 7;
  localparam int IX_INT      = 8;
  localparam int INT_W       = 5;
  localparam int IX_EXT      = 13;
  localparam int EXT_W       = 16;
  localparam int SYNC_W      = 29;
  localparam logic [SYNC_W-1:0] SYNC_RST = 29'h0000_0008;
  // ------------------------------------------------------------
  // power modes
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    PM_RESTART = 6'h01,
    PM_RUN     = 6'h02,
    PM_SLEEP   = 6'h04,
    PM_STOP    = 6'h08,
    PM_STANDBY = 6'h10,
    PM_IDLE    = 6'h20
  } pms_mode_t;
endpackage
`default_nettype wire

// ---- verilog/pms_sync_if.sv ----
// pms_sync_if: raw asynchronous inputs and their filtered copies
`default_nettype none
interface pms_sync_if;
  import pms_pkg::*;
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] clean;
  modport bank (input raw, output clean);
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// ---- verilog/pms_sync_bank.sv ----
// pms_sync_bank: three-stage synchroniser with agreement filter per lane
`default_nettype none
module pms_sync_bank (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic clk_en_i,
  pms_sync_if.bank  io
);
  import pms_pkg::*;
  for (genvar i = 0; i < SYNC_W; i++) begin : g_lane
    logic s1_q, s2_q, s3_q, cl_q;
    logic s1_d, s2_d, s3_d, cl_d;
    // the first stage feeds only the second
    always_comb begin
      s1_d = io.raw[i];
      s2_d = s1_q;
      s3_d = s2_q;
      cl_d = (s2_q == s3_q) ? s3_q : cl_q;
    end
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        s1_q <= SYNC_RST[i];
        s2_q <= SYNC_RST[i];
        s3_q <= SYNC_RST[i];
        cl_q <= SYNC_RST[i];
      end else if (clk_en_i) begin
        s1_q <= s1_d;
        s2_q <= s2_d;
        s3_q <= s3_d;
        cl_q <= cl_d;
      end
    end
    assign io.clean[i] = cl_q;
  end
endmodule // pms_sync_bank
`default_nettype wire

// ---- verilog/pms_supervisor.sv ----
// pms_supervisor: reset supervision, supply monitor and power-mode sequencing
//
// The implementer's own choices: the register addresses and register access over APB.
`default_nettype none
module pms_supervisor (
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       clk_en_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [11:0]                paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic [31:0]                     prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic                       main_supply_ok_i,
  input  wire logic                       analog_supply_ok_i,
  input  wire logic                       supply_below_level_i,
  input  wire logic                       analog_check_off_i,
  input  wire logic                       external_reset_pin_n_i,
  input  wire logic                       independent_watchdog_rst_i,
  input  wire logic                       wakeup_pin_i,
  input  wire logic                       rtc_alarm_i,
  input  wire logic [pms_pkg::INT_W-1:0]  int_wake_i,
  input  wire logic [pms_pkg::EXT_W-1:0]  external_event_lines_i,
  input  wire logic                       cpu_sleep_req_i,
  input  wire logic                       cpu_wake_evt_i,
  output logic                            chip_reset_o,
  output logic                            regulator_en_o,
  output logic                            regulator_lp_o,
  output logic                            core_power_o,
  output logic                            cpu_clk_en_o,
  output logic                            core_clk_en_o,
  output logic                            pll_en_o,
  output logic                            internal_fast_rc_osc_en_o,
  output logic                            external_fast_osc_en_o,
  output logic                            backup_clk_en_o,
  output logic [2:0]                      monitor_level_o,
  output logic                            irq_o
);
  import pms_pkg::*;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  pms_sync_if sif ();
  assign sif.raw = {external_event_lines_i, int_wake_i, analog_check_off_i, rtc_alarm_i,
                    wakeup_pin_i, independent_watchdog_rst_i, external_reset_pin_n_i,
                    supply_below_level_i, analog_supply_ok_i, main_supply_ok_i};

  pms_sync_bank u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .clk_en_i  (clk_en_i),
    .io        (sif.bank)
  );

  logic [SYNC_W-1:0] cl;
  logic              prev_low_q, prev_wk_q, prev_rtc_q;
  logic              prev_low_d, prev_wk_d, prev_rtc_d;
  logic              wk_rise, rtc_rise, low_rise, low_fall;
  logic              supply_bad, rst_req;
  assign cl = sif.clean;

  always_comb begin
    prev_low_d = cl[IX_MON_LOW];
    prev_wk_d  = cl[IX_WAKE];
    prev_rtc_d = cl[IX_RTC];
  end
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      prev_low_q <= 1'b0;
      prev_wk_q  <= 1'b0;
      prev_rtc_q <= 1'b0;
    end else if (clk_en_i) begin
      prev_low_q <= prev_low_d;
      prev_wk_q  <= prev_wk_d;
      prev_rtc_q <= prev_rtc_d;
    end
  end

  assign wk_rise  = cl[IX_WAKE] & ~prev_wk_q;
  assign rtc_rise = cl[IX_RTC] & ~prev_rtc_q;
  assign low_rise = cl[IX_MON_LOW] & ~prev_low_q;
  assign low_fall = ~cl[IX_MON_LOW] & prev_low_q;
  // analog lane is skipped when the option bit trades safety for current
  assign supply_bad = ~cl[IX_MAIN_OK] | (~cl[IX_ANA_OK] & ~cl[IX_ANA_OFF]);
  assign rst_req = supply_bad | ~cl[IX_RSTPIN_N] | cl[IX_WDG];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [CTRL_W-1:0]  ctrl_q, ctrl_d;
  logic [WMASK_W-1:0] wmask_q, wmask_d;
  logic [STAT_W-1:0]  stat_q, stat_d, imask_q, imask_d, stat_set;
  logic [31:0]        rdata_q, rdata_d;
  logic               ph_q, ph_d;
  logic               acc, wr, rd, hit;
  logic [31:0]        rmux;
  pms_mode_t          st_q, st_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic               wake_hit, mon_fall_evt, mon_rise_evt;

  assign acc = psel_i & penable_i & ph_q & clk_en_i;
  assign wr  = acc & pwrite_i;
  assign rd  = acc & ~pwrite_i;

  always_comb begin
    hit  = 1'b1;
    rmux = 32'h0000_0000;
    if (paddr_i == OFF_CTRL) begin
      rmux[CTRL_W-1:0] = ctrl_q;
    end else if (paddr_i == OFF_WMASK) begin
      rmux[WMASK_W-1:0] = wmask_q;
    end else if (paddr_i == OFF_STATUS) begin
      rmux[STAT_W-1:0] = stat_q;
    end else if (paddr_i == OFF_IMASK) begin
      rmux[STAT_W-1:0] = imask_q;
    end else if (paddr_i == OFF_MODE) begin
      rmux[5:0] = st_q;
      rmux[8]   = cl[IX_MON_LOW];
      rmux[9]   = supply_bad;
    end else begin
      hit = 1'b0;
    end
  end

  assign pready_o  = acc;
  assign pslverr_o = acc & ~hit;
  assign prdata_o  = rdata_q;

  // supply monitor edges, gated by enable and edge selection
  assign mon_fall_evt = ctrl_q[CT_MON_EN] & ctrl_q[CT_MON_FALL] & low_rise;
  assign mon_rise_evt = ctrl_q[CT_MON_EN] & ctrl_q[CT_MON_RISE] & low_fall;

  // any enabled external line or internal source (monitor output first)
  assign wake_hit = |({cl[IX_INT +: INT_W], cl[IX_EXT +: EXT_W]} & wmask_q)
                  | (wmask_q[EXT_W] & (mon_fall_evt | mon_rise_evt));

  always_comb begin
    stat_set = '0;
    stat_set[SB_MON_FALL]  = mon_fall_evt;
    stat_set[SB_MON_RISE]  = mon_rise_evt;
    stat_set[SB_STBY_EXIT] = (st_q == PM_STANDBY) & (rst_req | wk_rise | rtc_rise);
    stat_set[SB_STOP_WAKE] = (st_q == PM_STOP) & wake_hit & ~rst_req;
  end

  always_comb begin
    ctrl_d  = ctrl_q;
    wmask_d = wmask_q;
    imask_d = imask_q;
    stat_d  = stat_q;
    rdata_d = rdata_q;
    ph_d    = psel_i & ~acc;
    if (psel_i & ~pwrite_i) begin
      rdata_d = rmux;
    end
    if (wr & (paddr_i == OFF_CTRL)) begin
      ctrl_d = pwdata_i[CTRL_W-1:0];
    end else if (wr & (paddr_i == OFF_WMASK)) begin
      wmask_d = pwdata_i[WMASK_W-1:0];
    end else if (wr & (paddr_i == OFF_IMASK)) begin
      imask_d = pwdata_i[STAT_W-1:0];
    end
    // read clears only what it returned, so an event landing mid-transfer survives
    if (rd & (paddr_i == OFF_STATUS)) begin
      stat_d = stat_q & ~rdata_q[STAT_W-1:0];
    end
    stat_d = stat_d | stat_set;
    // the deep request is one-shot: it is dropped once standby is taken
    if (st_q == PM_STANDBY) begin
      ctrl_d[CT_DEEP] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_q  <= CTRL_RST;
      wmask_q <= WMASK_RST;
      imask_q <= STAT_RST;
      stat_q  <= STAT_RST;
      rdata_q <= 32'h0000_0000;
      ph_q    <= 1'b0;
    end else if (clk_en_i) begin
      ctrl_q  <= ctrl_d;
      wmask_q <= wmask_d;
      imask_q <= imask_d;
      stat_q  <= stat_d;
      rdata_q <= rdata_d;
      ph_q    <= ph_d;
    end
  end

  assign irq_o = |(stat_q & imask_q);

  // ------------------------------------------------------------
  // power-mode sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      PM_RESTART: begin
        if (rst_req) begin
          cnt_d = '0;
        end else if (cnt_q == CNT_W'(STARTUP_CYC - 1)) begin
          st_d = PM_RUN;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      PM_RUN: begin
        if (cpu_sleep_req_i & ~ctrl_q[CT_DEEP]) begin
          st_d = PM_SLEEP;
        end else if (cpu_sleep_req_i & ctrl_q[CT_STANDBY]) begin
          st_d = PM_STANDBY;
        end else if (cpu_sleep_req_i) begin
          st_d = PM_STOP;
        end
      end
      PM_SLEEP: begin
        if (cpu_wake_evt_i) begin
          st_d = PM_RUN;
        end
      end
      PM_STOP: begin
        if (wake_hit) begin
          st_d = PM_RUN;
        end
      end
      PM_STANDBY: begin
        if (wk_rise | rtc_rise) begin
          st_d = PM_RESTART;
        end
      end
      default: st_d = PM_RESTART;
    endcase
    if (rst_req) begin
      st_d  = PM_RESTART;
      cnt_d = '0;
    end else if (st_d == PM_RESTART && st_q != PM_RESTART) begin
      cnt_d = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_q  <= PM_RESTART;
      cnt_q <= '0;
    end else if (clk_en_i) begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // outputs decoded from the one-hot mode flops
  assign chip_reset_o   = (st_q == PM_RESTART);
  assign regulator_en_o = (st_q != PM_STANDBY);
  assign core_power_o   = (st_q != PM_STANDBY);
  assign regulator_lp_o = (st_q == PM_STOP) & ctrl_q[CT_STOP_LP];
  assign cpu_clk_en_o   = (st_q == PM_RUN);
  assign core_clk_en_o  = (st_q == PM_RUN) | (st_q == PM_SLEEP) | (st_q == PM_RESTART);
  assign pll_en_o       = (st_q == PM_RUN) | (st_q == PM_SLEEP);
  assign internal_fast_rc_osc_en_o = core_clk_en_o;
  assign external_fast_osc_en_o    = (st_q == PM_RUN) | (st_q == PM_SLEEP);
  // backup-domain clocks never follow the mode
  assign backup_clk_en_o = 1'b1;
  assign monitor_level_o = ctrl_q[CT_LVL_LO +: 3];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_supply_hold: assert property (clk_en_i && !cl[IX_MAIN_OK] |=> chip_reset_o)
    else $error("chip left reset with main supply low");
  a_analog_fall: assert property (clk_en_i && !cl[IX_ANA_OK] && !cl[IX_ANA_OFF] |=> chip_reset_o)
    else $error("analog supply fall did not hold reset");
  a_monitor_irq: assert property (clk_en_i && mon_fall_evt |=> stat_q[SB_MON_FALL])
    else $error("supply fall event not recorded");
  a_stop_regul: assert property (st_q == PM_STOP |-> regulator_en_o && regulator_lp_o == ctrl_q[CT_STOP_LP])
    else $error("stop regulation mode wrong");
  a_standby_off: assert property (st_q == PM_STANDBY |-> !regulator_en_o && !core_power_o && !pll_en_o)
    else $error("standby left regulator or core powered");
  a_sleep_clk: assert property (st_q == PM_SLEEP |-> !cpu_clk_en_o && core_clk_en_o)
    else $error("sleep clock gating wrong");
  a_stop_clk: assert property (st_q == PM_STOP |-> !core_clk_en_o && !internal_fast_rc_osc_en_o
                               && !external_fast_osc_en_o)
    else $error("stop left a fast clock running");
  a_stop_wake: assert property (st_q == PM_STOP && clk_en_i && wake_hit && !rst_req |=> st_q == PM_RUN)
    else $error("enabled event did not end stop");
  a_standby_exit: assert property (st_q == PM_STANDBY && clk_en_i && wk_rise |=> chip_reset_o)
    else $error("wakeup pin rise did not leave standby");
  a_restart_len: assert property ($rose(chip_reset_o) |-> chip_reset_o [*8])
    else $error("restart sequence too short");
  a_backup_clk: assert property (st_q == PM_STANDBY || st_q == PM_STOP |-> backup_clk_en_o)
    else $error("backup clocks stopped");

endmodule // pms_supervisor
`default_nettype wire

// ---- sim/pms_core_model.sv ----
// pms_core_model: processor-core stand-in that asks for low-power entry and raises pending events
`default_nettype none
module pms_core_model (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       sleep_cmd_i,
  input  wire logic       wake_cmd_i,
  input  wire logic [3:0] wake_dly_i,
  input  wire logic       cpu_clk_en_i,
  output logic            cpu_sleep_req_o,
  output logic            cpu_wake_evt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       sleep_q;
  logic       wake_q;
  logic [4:0] cnt_q;
  // a stopped core cannot execute another wait-for-interrupt, so the request needs a running clock
  always_ff @(posedge sys_clk_i) begin
    sleep_q <= sleep_cmd_i;
    wake_q <= wake_cmd_i;
    cpu_sleep_req_o <= sleep_cmd_i && !sleep_q && cpu_clk_en_i && !rst_i;
    if (rst_i) begin
      cnt_q <= 5'h00;
      cpu_wake_evt_o <= 1'b0;
    end else begin
      if (wake_cmd_i && !wake_q)
        cnt_q <= {1'b0, wake_dly_i} + 5'h01;
      else if (cnt_q != 5'h00)
        cnt_q <= cnt_q - 5'h01;
      // event stays pending until the core is clocked again and takes it
      if (cnt_q == 5'h01)
        cpu_wake_evt_o <= 1'b1;
      else if (cpu_clk_en_i)
        cpu_wake_evt_o <= 1'b0;
    end
  end
endmodule // pms_core_model
`default_nettype wire

// ---- sim/power_mode_supervisor_tb.sv ----
// power_mode_supervisor_tb: self-checking bench for the power-mode supervisor
`default_nettype none
module power_mode_supervisor_tb;
  import pms_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [9:0] M_RUN = 10'h17F, M_SLEEP = 10'h15F, M_STOP = 10'h141, M_STOP_LP = 10'h1C1;
  localparam logic [9:0] M_STBY = 10'h001, M_RST = 10'h355;
  logic        sys_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h00000000, prdata_o, rnd = 32'h00008DB4;
  logic        pready_o, pslverr_o, irq_o, cpu_sleep_req_i, cpu_wake_evt_i;
  logic        main_supply_ok_i = 1'b1, analog_supply_ok_i = 1'b1, supply_below_level_i = 1'b0;
  logic        analog_check_off_i = 1'b0, external_reset_pin_n_i = 1'b1, independent_watchdog_rst_i = 1'b0;
  logic        wakeup_pin_i = 1'b0, rtc_alarm_i = 1'b0, sleep_cmd = 1'b0, wake_cmd = 1'b0;
  logic [4:0]  int_wake_i = 5'h00;
  logic [15:0] external_event_lines_i = 16'h0000;
  logic [3:0]  wake_dly = 4'h0;
  logic        chip_reset_o, regulator_en_o, regulator_lp_o, core_power_o, cpu_clk_en_o, core_clk_en_o;
  logic        pll_en_o, internal_fast_rc_osc_en_o, external_fast_osc_en_o, backup_clk_en_o;
  logic [2:0]  monitor_level_o;
  logic [32:0] exp_q[$];
  int          n_fail = 0, samples_checked = 0, cyc = 0, m = 0;

  pms_supervisor uut (.sys_clk_i, .rst_i, .clk_en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .main_supply_ok_i, .analog_supply_ok_i, .supply_below_level_i,
    .analog_check_off_i, .external_reset_pin_n_i, .independent_watchdog_rst_i, .wakeup_pin_i, .rtc_alarm_i,
    .int_wake_i, .external_event_lines_i, .cpu_sleep_req_i, .cpu_wake_evt_i, .chip_reset_o, .regulator_en_o,
    .regulator_lp_o, .core_power_o, .cpu_clk_en_o, .core_clk_en_o, .pll_en_o, .internal_fast_rc_osc_en_o,
    .external_fast_osc_en_o, .backup_clk_en_o, .monitor_level_o, .irq_o);
  pms_core_model core (.sys_clk_i, .rst_i, .sleep_cmd_i(sleep_cmd), .wake_cmd_i(wake_cmd),
    .wake_dly_i(wake_dly), .cpu_clk_en_i(cpu_clk_en_o), .cpu_sleep_req_o(cpu_sleep_req_i),
    .cpu_wake_evt_o(cpu_wake_evt_i));

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_mode(input logic [9:0] e);
    check({chip_reset_o, regulator_en_o, regulator_lp_o, core_power_o, cpu_clk_en_o, core_clk_en_o,
           pll_en_o, internal_fast_rc_osc_en_o, external_fast_osc_en_o, backup_clk_en_o}, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // ready is sampled at the rising edge; the request is released only after it
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i) penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h00000000);
  endtask
  task automatic go_sleep();
    sleep_cmd <= 1'b1;
    tick(1);
    sleep_cmd <= 1'b0;
    tick(4);
  endtask

  always @(posedge sys_clk_i)
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i)
      check({pslverr_o, prdata_o}, exp_q.pop_front());
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      complete_run();
    end
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    tick(6);
    rst_i <= 1'b0;
    tick(STARTUP_CYC + 10);
    chk_mode(M_RUN);
    rd(OFF_CTRL, 32'(CTRL_RST), 1'b0);
    rd(OFF_WMASK, 32'(WMASK_RST), 1'b0);
    rd(OFF_STATUS, 32'(STAT_RST), 1'b0);
    rd(OFF_MODE, 32'h00000002, 1'b0);
    rd(12'h014, 32'h00000000, 1'b1);
    clk_en_i <= 1'b0;
    fork
      rd(OFF_MODE, 32'h00000002, 1'b0);
      begin
        tick(4);
        check(pready_o, 1'b0);
        clk_en_i <= 1'b1;
      end
    join
    $display("test reset done");
    main_supply_ok_i <= 1'b0;
    tick(8);
    chk_mode(M_RST);
    main_supply_ok_i <= 1'b1;
    tick(4);
    chk_mode(M_RST);
    tick(STARTUP_CYC + 6);
    chk_mode(M_RUN);
    analog_supply_ok_i <= 1'b0;
    tick(8);
    chk_mode(M_RST);
    analog_check_off_i <= 1'b1;
    tick(STARTUP_CYC + 10);
    chk_mode(M_RUN);
    analog_supply_ok_i <= 1'b1;
    analog_check_off_i <= 1'b0;
    $display("test supply done");
    rnd = xs(rnd);
    wr(OFF_IMASK, 32'h00000001);
    wr(OFF_CTRL, {23'h000000, rnd[2:0], 6'h07});
    tick(1);
    check(monitor_level_o, rnd[2:0]);
    supply_below_level_i <= 1'b1;
    tick(8);
    check(irq_o, 1'b1);
    rd(OFF_STATUS, 32'h00000001, 1'b0);
    tick(1);
    check(irq_o, 1'b0);
    supply_below_level_i <= 1'b0;
    tick(8);
    check(irq_o, 1'b0);
    rd(OFF_STATUS, 32'h00000002, 1'b0);
    wr(OFF_CTRL, 32'h00000006);
    supply_below_level_i <= 1'b1;
    tick(8);
    rd(OFF_STATUS, 32'h00000000, 1'b0);
    supply_below_level_i <= 1'b0;
    $display("test monitor done");
    wake_dly <= rnd[7:4];
    go_sleep();
    chk_mode(M_SLEEP);
    wake_cmd <= 1'b1;
    tick(32'(rnd[7:4]) + 6);
    chk_mode(M_RUN);
    wake_cmd <= 1'b0;
    $display("test sleep done");
    for (int k = 0; k < 3; k++) begin
      rnd = xs(rnd);
      m = (k < 2) ? 32'(rnd[3:0]) : 17 + 32'(rnd[1:0]);
      wr(OFF_WMASK, 32'h00000001 << m);
      wr(OFF_CTRL, (k == 1) ? 32'h00000018 : 32'h00000010);
      go_sleep();
      chk_mode((k == 1) ? M_STOP_LP : M_STOP);
      {int_wake_i, external_event_lines_i} <= ~(21'h000001 << m);
      tick(8);
      chk_mode((k == 1) ? M_STOP_LP : M_STOP);
      {int_wake_i, external_event_lines_i} <= 21'h1FFFFF;
      tick(8);
      chk_mode(M_RUN);
      rd(OFF_STATUS, 32'h00000008, 1'b0);
      {int_wake_i, external_event_lines_i} <= 21'h000000;
    end
    $display("test stop done");
    for (int k = 0; k < 4; k++) begin
      wr(OFF_CTRL, 32'h00000030);
      go_sleep();
      chk_mode(M_STBY);
      external_event_lines_i <= 16'hFFFF;
      tick(8);
      chk_mode(M_STBY);
      external_event_lines_i <= 16'h0000;
      wakeup_pin_i <= (k == 0);
      rtc_alarm_i <= (k == 1);
      external_reset_pin_n_i <= (k != 2);
      independent_watchdog_rst_i <= (k == 3);
      tick(8);
      chk_mode(M_RST);
      wakeup_pin_i <= 1'b0;
      rtc_alarm_i <= 1'b0;
      external_reset_pin_n_i <= 1'b1;
      independent_watchdog_rst_i <= 1'b0;
      tick(STARTUP_CYC + 8);
      chk_mode(M_RUN);
      if (k < 2)
        rd(OFF_STATUS, 32'h00000004, 1'b0);
    end
    $display("test standby done");
    complete_run();
  end
endmodule // power_mode_supervisor_tb
`default_nettype wire
